/* verilog/opfc_pkg.sv */
/*
 * Package for the output-processing and flag-control block: constants, types.
 * Assumes a single 250 MHz system clock and a minute-of-day counter supplied outside.
 */
package opfc_pkg;

  // ********************************************************************
  // Timing
  // ********************************************************************
  localparam int CLK_MHZ          = 250;
  localparam int SLOW_INTEG_NS    = 16670000;
  localparam int FAST_INTEG_NS    = 250000;
  localparam int SLOW_INTEG_CYC   = (SLOW_INTEG_NS / 1000) * CLK_MHZ;
  localparam int FAST_INTEG_CYC   = (FAST_INTEG_NS / 1000) * CLK_MHZ;
  localparam int MIN_PER_DAY      = 1440;

  // ********************************************************************
  // Codes and flags
  // ********************************************************************
  localparam logic [4:0] RANGE_SLOW_LO = 5'h01;
  localparam logic [4:0] RANGE_SLOW_HI = 5'h08;
  localparam logic [4:0] RANGE_FAST_LO = 5'h0b;
  localparam logic [4:0] RANGE_FAST_HI = 5'h12;
  localparam logic [6:0] CMD_SET_LO    = 7'h0a;
  localparam logic [6:0] CMD_SET_HI    = 7'h13;
  localparam logic [6:0] CMD_CLR_LO    = 7'h14;
  localparam logic [6:0] CMD_CLR_HI    = 7'h1d;
  localparam int         NUM_FLAGS     = 10;
  localparam int         FLAG_OUT      = 0;
  localparam int         FLAG_INHIBIT  = 9;
  localparam logic [9:0] FLAGS_RST     = 10'h000;

  // Sentinels
  localparam logic [31:0] OVR_SENTINEL  = 32'h80000000;
  localparam logic [31:0] OVR_LOWRES    = 32'hffffe4a9;
  localparam logic [31:0] OVR_HIGHRES   = 32'hfffe7961;

  // Full-scale spans in microvolts, index 0..7
  localparam logic [31:0] SPAN_UV [8] = '{32'h000005dc, 32'h00001388, 32'h00003a98,
                                          32'h0000c350, 32'h000249f0, 32'h0007a120,
                                          32'h0016e360, 32'h004c4b40};

  typedef enum logic [1:0] {
    OPFC_IDLE  = 2'b00,
    OPFC_DIV   = 2'b01,
    OPFC_WRITE = 2'b11
  } opfc_state_t;

  typedef struct packed {
    logic        valid;
    logic [6:0]  cmd;
    logic        cond;
  } opfc_ctl_t;

  typedef struct packed {
    logic        valid;
    logic [31:0] value;
    logic        to_input;
  } opfc_res_t;

endpackage

/* verilog/opfc_core.sv */
/*
 * Output processing and flag control: range decode, overrange substitution,
 * averaging accumulator, ten program flags and the time-of-day interval test.
 * Assumes synchronous inputs on sys_clk and one-cycle step strobes from a sequencer.
 */
`timescale 1ns/1ps

// Summary of operation
// - Range code selects span and integration time
// - Sixteen codes, slow and fast, map to eight ascending full-scale spans
// - Overranged input stored as largest negative
// - Overrange output reads -6999 or -99999
// - Intermediate step counts and accumulates input
// - Final average divides, stores, clears sum
// - Sampling only on output step execution
// - Final processing only while output flag high
// - Ten flags: output, user, inhibit
// - Table start clears flags zero and nine
// - User flags hold until step or toggle
// - False test drives flag zero/nine low
// - False test leaves user flags unchanged
// - Inhibit flag blocks all intermediate accumulation
// - Interval test true at offset within period
// - Interval restarts midnight; short last interval
// - Command ten with true test sets flag
// - Manual toggles of user flags accepted
// - Destination default final, selectable to input
module opfc_core
  import opfc_pkg::*;
#(
  parameter int CNT_W = 16
)
(
  input  wire logic         sys_clk,
  input  wire logic         rst_n,
  input  wire logic [4:0]   range_code,
  input  wire logic         in_valid,
  input  wire logic [31:0]  in_value,
  input  wire logic         in_overrange,
  input  wire logic         table_start,
  input  wire opfc_ctl_t    ctl,
  input  wire logic         time_test,
  input  wire logic [10:0]  time_offset,
  input  wire logic [10:0]  time_period,
  input  wire logic [10:0]  minute_of_day,
  input  wire logic         toggle_valid,
  input  wire logic [3:0]   toggle_idx,
  input  wire logic         avg_step,
  input  wire logic [31:0]  avg_input,
  input  wire logic         dest_sel_valid,
  input  wire logic         dest_to_input,
  input  wire logic         out_highres,
  output opfc_res_t         result,
  output logic [31:0]       out_format,
  output logic [31:0]       stored_value,
  output logic [31:0]       span_uv,
  output logic              fast_integ,
  output logic [23:0]       integ_cycles,
  output logic              range_bad,
  output logic [9:0]        flags,
  output logic              time_hit
);

  // ********************************************************************
  // Elaboration checks
  // ********************************************************************
  if (CNT_W < 2 || CNT_W > 32)
  begin : g_cnt_w_bad
    $error("CNT_W out of range");
  end

  if (SLOW_INTEG_CYC < 1 || SLOW_INTEG_CYC > 32'h00ffffff)
  begin : g_slow_bad
    $error("Slow integration count does not fit 24 bits");
  end

  if (FAST_INTEG_CYC < 1 || FAST_INTEG_CYC > 32'h00ffffff)
  begin : g_fast_bad
    $error("Fast integration count does not fit 24 bits");
  end

  if (NUM_FLAGS != 10 || FLAG_OUT != 0 || FLAG_INHIBIT != NUM_FLAGS - 1)
  begin : g_flag_bad
    $error("Flag layout differs from the ten-flag register");
  end

  if (MIN_PER_DAY > 32'h000007ff)
  begin : g_day_bad
    $error("Minute of day does not fit 11 bits");
  end

  for (genvar g = 1; g < 8; g++)
  begin : g_span_order
    if (SPAN_UV[g] <= SPAN_UV[g - 1])
    begin : g_span_bad
      $error("Span table is not ascending");
    end
  end

  // ********************************************************************
  // Range decode and overrange
  // ********************************************************************
  logic [31:0] span_d;
  logic [31:0] span_q;
  logic [31:0] stored_d;
  logic [31:0] stored_q;
  logic        fast_d;
  logic        fast_q;
  logic        bad_d;
  logic        bad_q;
  logic [23:0] integ_d;
  logic [23:0] integ_q;
  logic [2:0]  ridx;

  always_comb
  begin
    span_d   = span_q;
    fast_d   = fast_q;
    integ_d  = integ_q;
    bad_d    = 1'b0;
    stored_d = stored_q;
    ridx     = 3'h0;
    if (range_code >= RANGE_SLOW_LO && range_code <= RANGE_SLOW_HI)
    begin
      ridx    = 3'(range_code - RANGE_SLOW_LO);
      span_d  = SPAN_UV[ridx];
      fast_d  = 1'b0;
      integ_d = 24'(SLOW_INTEG_CYC);
    end
    else if (range_code >= RANGE_FAST_LO && range_code <= RANGE_FAST_HI)
    begin
      ridx    = 3'(range_code - RANGE_FAST_LO);
      span_d  = SPAN_UV[ridx];
      fast_d  = 1'b1;
      integ_d = 24'(FAST_INTEG_CYC);
    end
    else
      bad_d = 1'b1;
    if (in_valid)
      stored_d = in_overrange ? OVR_SENTINEL : in_value;
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      span_q   <= 32'h00000000;
      fast_q   <= 1'b0;
      integ_q  <= 24'h000000;
      bad_q    <= 1'b0;
      stored_q <= 32'h00000000;
    end
    else
    begin
      span_q   <= span_d;
      fast_q   <= fast_d;
      integ_q  <= integ_d;
      bad_q    <= bad_d;
      stored_q <= stored_d;
    end
  end

  // ********************************************************************
  // Interval test
  // ********************************************************************
  logic        hit_d;
  logic        hit_q;
  logic        day_ok;
  logic [10:0] phase;

  always_comb
  begin
    phase  = 11'h000;
    day_ok = (minute_of_day < 11'(MIN_PER_DAY));
    if (time_period != 11'h000)
      phase = minute_of_day % time_period;
    hit_d = day_ok && (time_period != 11'h000) && (phase == time_offset);
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      hit_q <= 1'b0;
    else
      hit_q <= hit_d;
  end

  // ********************************************************************
  // Flags
  // ********************************************************************
  logic [9:0] flags_d;
  logic [9:0] flags_q;
  logic       cond;
  logic [3:0] fidx;

  function automatic logic in_rng(input logic [6:0] c, input logic [6:0] lo,
                                  input logic [6:0] hi);
    in_rng = (c >= lo) && (c <= hi);
  endfunction

  function automatic logic auto_clr(input logic [3:0] idx);
    auto_clr = (idx == 4'(FLAG_OUT)) || (idx == 4'(FLAG_INHIBIT));
  endfunction

  always_comb
  begin
    flags_d = flags_q;
    fidx    = 4'h0;
    cond    = time_test ? hit_d : ctl.cond;
    if (table_start)
    begin
      flags_d[FLAG_OUT]     = 1'b0;
      flags_d[FLAG_INHIBIT] = 1'b0;
    end
    else if (ctl.valid && in_rng(ctl.cmd, CMD_SET_LO, CMD_SET_HI))
    begin
      fidx = 4'(ctl.cmd - CMD_SET_LO);
      if (cond)
        flags_d[fidx] = 1'b1;
      else if (auto_clr(fidx))
        flags_d[fidx] = 1'b0;
    end
    else if (ctl.valid && in_rng(ctl.cmd, CMD_CLR_LO, CMD_CLR_HI))
    begin
      fidx = 4'(ctl.cmd - CMD_CLR_LO);
      if (cond)
        flags_d[fidx] = 1'b0;
      else if (auto_clr(fidx))
        flags_d[fidx] = 1'b0;
    end
    else if (toggle_valid && toggle_idx >= 4'h1 && toggle_idx <= 4'h8)
      flags_d[toggle_idx] = ~flags_q[toggle_idx];
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
      flags_q <= FLAGS_RST;
    else
      flags_q <= flags_d;
  end

  // ********************************************************************
  // Averaging
  // ********************************************************************
  opfc_state_t      st_d;
  opfc_state_t      st_q;
  logic [31:0]      sum_d;
  logic [31:0]      sum_q;
  logic [31:0]      quo_d;
  logic [31:0]      quo_q;
  logic [CNT_W-1:0] cnt_d;
  logic [CNT_W-1:0] cnt_q;
  logic             dest_d;
  logic             dest_q;
  opfc_res_t        res_d;
  opfc_res_t        res_q;
  logic [31:0]      fmt_d;
  logic [31:0]      fmt_q;

  always_comb
  begin
    st_d   = st_q;
    sum_d  = sum_q;
    cnt_d  = cnt_q;
    quo_d  = quo_q;
    dest_d = dest_q;
    res_d  = '0;
    fmt_d  = fmt_q;
    if (dest_sel_valid)
      dest_d = dest_to_input;
    case (st_q)
      OPFC_IDLE:
      begin
        if (avg_step)
        begin
          if (!flags_q[FLAG_INHIBIT])
          begin
            cnt_d = cnt_q + 1'b1;
            sum_d = sum_q + avg_input;
          end
          if (flags_q[FLAG_OUT])
            st_d = OPFC_DIV;
        end
      end
      OPFC_DIV:
      begin
        quo_d = (cnt_q == '0) ? 32'h00000000 : sum_q / 32'(cnt_q);
        st_d  = OPFC_WRITE;
      end
      OPFC_WRITE:
      begin
        res_d.valid    = 1'b1;
        res_d.value    = quo_q;
        res_d.to_input = dest_q;
        if (quo_q == OVR_SENTINEL)
          fmt_d = out_highres ? OVR_HIGHRES : OVR_LOWRES;
        else
          fmt_d = quo_q;
        sum_d = 32'h00000000;
        cnt_d = '0;
        st_d  = OPFC_IDLE;
      end
      default:
        st_d = OPFC_IDLE;
    endcase
  end

  always_ff @(posedge sys_clk)
  begin
    if (!rst_n)
    begin
      st_q   <= OPFC_IDLE;
      sum_q  <= 32'h00000000;
      cnt_q  <= '0;
      quo_q  <= 32'h00000000;
      dest_q <= 1'b0;
      res_q  <= '0;
      fmt_q  <= 32'h00000000;
    end
    else
    begin
      st_q   <= st_d;
      sum_q  <= sum_d;
      cnt_q  <= cnt_d;
      quo_q  <= quo_d;
      dest_q <= dest_d;
      res_q  <= res_d;
      fmt_q  <= fmt_d;
    end
  end

  // ********************************************************************
  // Outputs
  // ********************************************************************
  assign result       = res_q;
  assign out_format   = fmt_q;
  assign stored_value = stored_q;
  assign span_uv      = span_q;
  assign fast_integ   = fast_q;
  assign integ_cycles = integ_q;
  assign range_bad    = bad_q;
  assign flags        = flags_q;
  assign time_hit     = hit_q;

endmodule

/* testbench/opfc_core_assertions.sv */
/* Port checker for opfc_core.
   Bound to every opfc_core instance; sees its ports only. */
`timescale 1ns/1ps
module opfc_core_chk
  import opfc_pkg::*;
(
  input wire logic        sys_clk,
  input wire logic        rst_n,
  input wire logic [4:0]  range_code,
  input wire logic        table_start,
  input wire opfc_ctl_t   ctl,
  input wire logic        time_test,
  input wire logic        toggle_valid,
  input wire logic        avg_step,
  input wire opfc_res_t   result,
  input wire logic [31:0] span_uv,
  input wire logic        fast_integ,
  input wire logic [23:0] integ_cycles,
  input wire logic [9:0]  flags
);
  // ****************
  // Properties
  // ****************
  default clocking @(posedge sys_clk); endclocking
  default disable iff (!rst_n);
  wire logic slow_c = range_code >= 5'h01 && range_code <= 5'h08;
  wire logic go = ctl.valid && !table_start && !time_test;
  sequence s_final_req;
    avg_step && flags[0];
  endsequence
  chk_slow_integ: assert property (slow_c |=> !fast_integ && integ_cycles == 24'd4167500)
    else $error("slow decode wrong");
  chk_fast_integ: assert property ((range_code >= 5'h0b && range_code <= 5'h12)
    |=> fast_integ && integ_cycles == 24'd62500)
    else $error("fast decode wrong");
  chk_span_map: assert property (slow_c |=> span_uv == SPAN_UV[$past(range_code) - 5'h01])
    else $error("span wrong");
  chk_table_clear: assert property (table_start |=> !flags[0] && !flags[9])
    else $error("flags not cleared");
  chk_user_hold: assert property (!ctl.valid && !toggle_valid |=> $stable(flags[8:1]))
    else $error("user flag moved");
  chk_false_low: assert property (go && !ctl.cond && (ctl.cmd == 7'h0a || ctl.cmd == 7'h13)
    |=> !flags[$past(ctl.cmd) == 7'h0a ? 0 : 9])
    else $error("flag not lowered");
  chk_true_set: assert property (go && ctl.cond && ctl.cmd >= 7'h0a && ctl.cmd <= 7'h13
    |=> flags[$past(ctl.cmd) - 7'h0a])
    else $error("flag not set");
  chk_final_lat: assert property (s_final_req |-> ##3 result.valid)
    else $error("no final result");
  chk_final_gate: assert property ($rose(result.valid) |-> $past(flags[0], 3))
    else $error("result without output flag");
endmodule
bind opfc_core opfc_core_chk u_opfc_core_chk (.sys_clk(sys_clk), .rst_n(rst_n),
  .range_code(range_code), .table_start(table_start), .ctl(ctl), .time_test(time_test),
  .toggle_valid(toggle_valid), .avg_step(avg_step), .result(result), .span_uv(span_uv),
  .fast_integ(fast_integ), .integ_cycles(integ_cycles), .flags(flags));

/* testbench/opfc_core_tb_top.sv */
/* Self-checking bench for opfc_core.
   Drives all inputs on the falling edge of sys_clk. */
`timescale 1ns/1ps
module opfc_core_tb_top
  import opfc_pkg::*;
;
  typedef struct packed {logic [4:0] code; logic [31:0] span; logic fast; logic bad;} opfc_row_t;
  logic        sys_clk, rst_n, in_valid, in_overrange, table_start, time_test, toggle_valid;
  logic        avg_step, dest_sel_valid, dest_to_input, out_highres, fast_integ, range_bad;
  logic        time_hit, to_in;
  logic [4:0]  range_code;
  logic [3:0]  toggle_idx;
  logic [10:0] time_offset, time_period, minute_of_day;
  logic [31:0] in_value, avg_input, out_format, stored_value, span_uv, fmt;
  logic [23:0] integ_cycles;
  logic [9:0]  flags;
  opfc_ctl_t   ctl;
  opfc_res_t   result;
  opfc_row_t   rows [20];
  int          n_mismatch, samples_checked;
  int          spans [8] = '{1500, 5000, 15000, 50000, 150000, 500000, 1500000, 5000000};
  logic [4:0]  bad [4] = '{5'h00, 5'h09, 5'h0a, 5'h13};
  logic [10:0] tt [4][4] = '{'{11'h000, 11'h007, 11'h59b, 11'h001},
    '{11'h000, 11'h007, 11'h59c, 11'h000}, '{11'h000, 11'h007, 11'h000, 11'h001},
    '{11'h003, 11'h03c, 11'h07b, 11'h001}};
  opfc_core u_opfc_core (.sys_clk(sys_clk), .rst_n(rst_n), .range_code(range_code),
    .in_valid(in_valid), .in_value(in_value), .in_overrange(in_overrange),
    .table_start(table_start), .ctl(ctl), .time_test(time_test), .time_offset(time_offset),
    .time_period(time_period), .minute_of_day(minute_of_day), .toggle_valid(toggle_valid),
    .toggle_idx(toggle_idx), .avg_step(avg_step), .avg_input(avg_input),
    .dest_sel_valid(dest_sel_valid), .dest_to_input(dest_to_input), .out_highres(out_highres),
    .result(result), .out_format(out_format), .stored_value(stored_value), .span_uv(span_uv),
    .fast_integ(fast_integ), .integ_cycles(integ_cycles), .range_bad(range_bad),
    .flags(flags), .time_hit(time_hit));
  // ****************
  // Tasks
  // ****************
  task automatic chk(input logic ok, input string m);
    samples_checked++;
    if (ok !== 1'b1)
    begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, m);
    end
  endtask
  task automatic print_verdict();
    $display("checked %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cstep(input logic [6:0] cmd, input logic cond);
    ctl = '{1'b1, cmd, cond};
    @(negedge sys_clk);
    ctl = '0;
    @(negedge sys_clk);
  endtask
  task automatic avg(input logic [31:0] v, input logic want, input logic [31:0] exp);
    logic got;
    got = 1'b0;
    avg_step = 1'b1;
    avg_input = v;
    @(negedge sys_clk);
    avg_step = 1'b0;
    repeat (4)
    begin
      @(negedge sys_clk);
      if (result.valid === 1'b1)
      begin
        got = 1'b1;
        to_in = result.to_input;
        fmt = out_format;
        chk(result.value === exp, "average value");
      end
    end
    chk(got === want, "final step presence");
    if (want && !got)
      print_verdict();
  endtask
  // ****************
  // Sequence
  // ****************
  initial
  begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  initial
  begin
    {rst_n, in_valid, in_overrange, table_start, time_test, toggle_valid, avg_step} = '0;
    {dest_sel_valid, dest_to_input, out_highres, range_code, toggle_idx} = '0;
    {time_offset, time_period, minute_of_day, in_value, avg_input, ctl} = '0;
    n_mismatch = 0;
    samples_checked = 0;
    for (int i = 0; i < 8; i++)
    begin
      rows[i] = '{5'(i + 1), 32'(spans[i]), 1'b0, 1'b0};
      rows[i + 8] = '{5'(i + 11), 32'(spans[i]), 1'b1, 1'b0};
      if (i < 4)
        rows[i + 16] = '{bad[i], 32'h0, 1'b0, 1'b1};
    end
    repeat (12) @(negedge sys_clk);
    chk(flags === 10'h000 && result.valid === 1'b0 && time_hit === 1'b0, "reset values");
    rst_n = 1'b1;
    foreach (rows[i])
    begin
      range_code = rows[i].code;
      @(negedge sys_clk);
      chk(range_bad === rows[i].bad, "range code check");
      if (!rows[i].bad)
        chk(span_uv === rows[i].span && fast_integ === rows[i].fast && integ_cycles ===
          (rows[i].fast ? 24'd62500 : 24'd4167500), "range decode");
    end
    $display("range table done");
    {in_valid, in_value} = {1'b1, 32'h00001234};
    @(negedge sys_clk);
    chk(stored_value === 32'h00001234, "stored reading");
    in_overrange = 1'b1;
    @(negedge sys_clk);
    {in_valid, in_overrange} = '0;
    chk(stored_value === 32'h80000000, "overrange sentinel");
    avg(32'd10, 0, 0);
    avg(32'd20, 0, 0);
    avg(32'd30, 0, 0);
    cstep(7'h0a, 1'b1);
    avg(32'd40, 1, 32'd25);
    chk(fmt === 32'd25, "formatted value");
    avg(32'd8, 1, 32'd8);
    chk(to_in === 1'b0, "default destination");
    $display("average done");
    cstep(7'h0d, 1'b1);
    cstep(7'h13, 1'b1);
    table_start = 1'b1;
    @(negedge sys_clk);
    table_start = 1'b0;
    chk(flags[0] === 1'b0 && flags[9] === 1'b0 && flags[3] === 1'b1, "table start");
    cstep(7'h13, 1'b1);
    avg(32'd1000, 0, 0);
    cstep(7'h1d, 1'b1);
    avg(32'd6, 0, 0);
    cstep(7'h0a, 1'b1);
    avg(32'd6, 1, 32'd6);
    cstep(7'h0a, 1'b0);
    cstep(7'h0d, 1'b0);
    chk(flags[0] === 1'b0 && flags[3] === 1'b1, "false test");
    cstep(7'h13, 1'b1);
    cstep(7'h13, 1'b0);
    chk(flags[9] === 1'b0, "false test inhibit");
    {toggle_valid, toggle_idx} = {1'b1, 4'h5};
    @(negedge sys_clk);
    toggle_idx = 4'h0;
    @(negedge sys_clk);
    toggle_valid = 1'b0;
    chk(flags[5] === 1'b1 && flags[0] === 1'b0, "manual toggle");
    $display("flags done");
    {dest_sel_valid, dest_to_input, out_highres} = 3'b111;
    @(negedge sys_clk);
    dest_sel_valid = 1'b0;
    cstep(7'h0a, 1'b1);
    avg(32'h80000000, 1, 32'h80000000);
    chk(to_in === 1'b1 && fmt === -32'sd99999, "high resolution sentinel");
    {dest_sel_valid, dest_to_input, out_highres} = 3'b100;
    @(negedge sys_clk);
    dest_sel_valid = 1'b0;
    avg(32'h80000000, 1, 32'h80000000);
    chk(to_in === 1'b0 && fmt === -32'sd6999, "low resolution sentinel");
    time_test = 1'b1;
    for (int i = 0; i < 4; i++)
    begin
      {time_offset, time_period, minute_of_day} = {tt[i][0], tt[i][1], tt[i][2]};
      cstep(7'h0a, 1'b0);
      chk(flags[0] === tt[i][3][0] && time_hit === tt[i][3][0], "interval test");
    end
    $display("interval done");
    rst_n = 1'b0;
    @(negedge sys_clk);
    chk(flags === 10'h000 && time_hit === 1'b0 && span_uv === 32'h0, "mid-run reset");
    rst_n = 1'b1;
    $display("reset done");
    print_verdict();
  end
endmodule
